// file: sim/fpm_front_panel_asserts.sv
`timescale 1ns/1ps
module fpm_front_panel_asserts
   import fpm_pkg::*;
#(
   parameter int unsigned NUM_PORTS = NUM_PORTS_DEF
) (
   input wire logic                         CORE_CLK,
   input wire logic                         RESET_N,
   input wire logic                         STARTUP_DONE,
   input wire logic                         FIRMWARE_ERROR,
   input wire fpm_ring_t                    RING_STATUS,
   input wire fpm_link_t                    LINK_STATUS,
   input wire logic                         MODE_INDICATOR_FIRST,
   input wire logic                         MODE_INDICATOR_SECOND,
   input wire logic [2:0]                   DISPLAY_MODE,
   input wire logic [NUM_PORTS-1:0]         PORT_CHASE,
   input wire logic                         PORT_CHASE_ACTIVE,
   input wire logic                         RING_MANAGER_LAMP,
   input wire logic                         REDUNDANT_LINK_LAMP,
   input wire logic                         FAULT_LAMP,
   input wire logic                         SIGNAL_CONTACT_CLOSED,
   input wire logic                         FACTORY_RESTORE,
   input wire logic                         MASK_STORED,
   input wire logic [NUM_PORTS+NUM_SUPPLY-1:0] FAULT_MASK
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // ****************************************
   // lamps
   // ****************************************
   ring_off_a: assert property (!RING_STATUS.is_manager [*2] |-> !RING_MANAGER_LAMP)
      else $error("ring lamp lit while not manager");
   ring_steady_a: assert property ((RING_STATUS == 2'h2) [*2] |-> RING_MANAGER_LAMP)
      else $error("ring lamp not steady for healthy ring");
   link_off_a: assert property (!LINK_STATUS.func_enabled [*2] |-> !REDUNDANT_LINK_LAMP)
      else $error("link lamp lit while function disabled");
   standby_on_a: assert property ((LINK_STATUS[3:1] == 3'h2) [*2] |-> REDUNDANT_LINK_LAMP)
      else $error("link lamp not steady for passive standby");
   icon_on_a: assert property ((LINK_STATUS[3:2] == 2'h3 && LINK_STATUS[0]) [*2] |-> REDUNDANT_LINK_LAMP)
      else $error("link lamp not steady with redundancy");
   startup_fault_a: assert property ((!STARTUP_DONE && !FIRMWARE_ERROR) [*2] |-> FAULT_LAMP)
      else $error("fault lamp dark during startup");
   contact_lamp_a: assert property (SIGNAL_CONTACT_CLOSED |-> !FAULT_LAMP && $past(STARTUP_DONE))
      else $error("contact closed while fault lamp lit");
   // ****************************************
   // mode and holds
   // ****************************************
   lamps_c_a: assert property ((DISPLAY_MODE == MODE_C)[*2] |-> !MODE_INDICATOR_FIRST && MODE_INDICATOR_SECOND)
      else $error("mode lamps wrong in mode C");
   mode_e_a: assert property ((DISPLAY_MODE == MODE_E)[*2] |-> !MODE_INDICATOR_SECOND)
      else $error("second mode lamp lit in mode E");
   mode_a_dark_a: assert property ((DISPLAY_MODE == MODE_A)[*2] ##0 !PORT_CHASE_ACTIVE
      |-> !MODE_INDICATOR_FIRST && !MODE_INDICATOR_SECOND)
      else $error("mode lamps lit in mode A");
   restore_clear_a: assert property (FACTORY_RESTORE |=> FAULT_MASK == '0 && DISPLAY_MODE == MODE_A)
      else $error("restore did not clear settings");
   mask_in_d_a: assert property (MASK_STORED |-> DISPLAY_MODE == MODE_D)
      else $error("mask stored outside mode D");
   pulse_once_a: assert property ((FACTORY_RESTORE || MASK_STORED) |=> !(FACTORY_RESTORE || MASK_STORED))
      else $error("hold pulse longer than one cycle");
   chase_idle_a: assert property (!PORT_CHASE_ACTIVE |-> PORT_CHASE == '0)
      else $error("port chase lit outside flash window");
   chase_onehot_a: assert property (PORT_CHASE_ACTIVE |-> $onehot(PORT_CHASE))
      else $error("port chase not one lamp at a time");
   cov_restore_c: cover property (FACTORY_RESTORE);
   cov_mask_c: cover property (MASK_STORED);
   cov_mode_e_c: cover property (DISPLAY_MODE == MODE_E);
endmodule
bind fpm_front_panel fpm_front_panel_asserts #(.NUM_PORTS(NUM_PORTS)) i_fpm_front_panel_asserts (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .STARTUP_DONE(STARTUP_DONE), .FIRMWARE_ERROR(FIRMWARE_ERROR),
   .RING_STATUS(RING_STATUS), .LINK_STATUS(LINK_STATUS), .MODE_INDICATOR_FIRST(MODE_INDICATOR_FIRST),
   .MODE_INDICATOR_SECOND(MODE_INDICATOR_SECOND), .DISPLAY_MODE(DISPLAY_MODE), .PORT_CHASE(PORT_CHASE),
   .PORT_CHASE_ACTIVE(PORT_CHASE_ACTIVE), .RING_MANAGER_LAMP(RING_MANAGER_LAMP),
   .REDUNDANT_LINK_LAMP(REDUNDANT_LINK_LAMP), .FAULT_LAMP(FAULT_LAMP),
   .SIGNAL_CONTACT_CLOSED(SIGNAL_CONTACT_CLOSED), .FACTORY_RESTORE(FACTORY_RESTORE),
   .MASK_STORED(MASK_STORED), .FAULT_MASK(FAULT_MASK));

// file: sim/fpm_operator.sv
`timescale 1ns/1ps
module fpm_operator (
   input wire logic clk,
   output logic     button_n
);
   initial button_n = 1'h1;
   // ****************************************
   // press with contact bounce, hold, release
   // ****************************************
   task automatic press(input int hold);
      @(negedge clk);
      button_n = 1'h0;
      @(negedge clk);
      button_n = 1'h1;
      @(negedge clk);
      button_n = 1'h0;
      repeat (hold) @(negedge clk);
      button_n = 1'h1;
      repeat (14) @(negedge clk);
   endtask
endmodule

// file: sim/test_fpm_front_panel.sv
`timescale 1ns/1ps
module test_fpm_front_panel
   import fpm_pkg::*;
;
   typedef struct {logic [2:0] mode; logic chk1; logic first; logic second;} fpm_row_t;
   logic       CORE_CLK, RESET_N, RESTORE_BTN_ENA, STARTUP_DONE, FIRST, SECOND, ACTIVE;
   logic       STARTUP_ERROR, FIRMWARE_ERROR, OTHER_FAULT;
   logic       RING_LAMP, LINK_LAMP, FAULT_LAMP, CONTACT, FACTORY_RESTORE, MASK_STORED;
   wire        BUTTON_N;
   logic [7:0] PORT_STATE, PORT_CHASE;
   logic [1:0] SUPPLY_STATE;
   logic [2:0] DISPLAY_MODE;
   logic [9:0] FAULT_MASK;
   fpm_ring_t  RING_STATUS;
   fpm_link_t  LINK_STATUS;
   int         num_errors, total_checks, n_restore, n_mask, n_chase;
   fpm_row_t   rows[5] = '{'{MODE_B, 1, 1, 0}, '{MODE_C, 1, 0, 1}, '{MODE_D, 1, 1, 1},
                          '{MODE_E, 0, 0, 0}, '{MODE_A, 1, 0, 0}};
   fpm_front_panel #(.IDLE_CYCLES(400), .RESTORE_HOLD_CYCLES(120), .RESTORE_FLASH_CYCLES(90),
      .MASK_HOLD_CYCLES(50), .MASK_FLASH_CYCLES(20), .FLASH_LEN_CYCLES(30), .DEBOUNCE_CYCLES(4),
      .BLINK_HALF_CYCLES(5)) i_fpm_front_panel (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
      .BUTTON_N(BUTTON_N), .RESTORE_BTN_ENA(RESTORE_BTN_ENA), .STARTUP_DONE(STARTUP_DONE),
      .STARTUP_ERROR(STARTUP_ERROR), .FIRMWARE_ERROR(FIRMWARE_ERROR), .OTHER_FAULT(OTHER_FAULT),
      .PORT_STATE(PORT_STATE),
      .SUPPLY_STATE(SUPPLY_STATE), .RING_STATUS(RING_STATUS), .LINK_STATUS(LINK_STATUS),
      .MODE_INDICATOR_FIRST(FIRST), .MODE_INDICATOR_SECOND(SECOND), .DISPLAY_MODE(DISPLAY_MODE),
      .PORT_CHASE(PORT_CHASE), .PORT_CHASE_ACTIVE(ACTIVE), .RING_MANAGER_LAMP(RING_LAMP),
      .REDUNDANT_LINK_LAMP(LINK_LAMP), .FAULT_LAMP(FAULT_LAMP), .SIGNAL_CONTACT_CLOSED(CONTACT),
      .FACTORY_RESTORE(FACTORY_RESTORE), .MASK_STORED(MASK_STORED), .FAULT_MASK(FAULT_MASK));
   fpm_operator i_fpm_operator (.clk(CORE_CLK), .button_n(BUTTON_N));
   initial begin
      CORE_CLK = 1'h0;
      forever #25 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) begin
      n_restore += (FACTORY_RESTORE === 1'h1);
      n_mask += (MASK_STORED === 1'h1);
      n_chase += (ACTIVE === 1'h1);
   end
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chk_blink(input logic fault_sel);
      int lit;
      lit = 0;
      repeat (12) begin
         @(negedge CORE_CLK);
         lit += fault_sel ? FAULT_LAMP : FIRST;
      end
      chk_bit(lit > 1 && lit < 11, 1'h1);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge CORE_CLK);
      num_errors++;
      give_verdict();
   end
   initial begin
      {RESET_N, STARTUP_DONE, PORT_STATE, SUPPLY_STATE, RING_STATUS, LINK_STATUS} = '0;
      {num_errors, total_checks, n_restore, n_mask, n_chase} = '0;
      {STARTUP_ERROR, FIRMWARE_ERROR, OTHER_FAULT} = 3'h0;
      RESTORE_BTN_ENA = 1'h1;
      repeat (6) @(negedge CORE_CLK);
      chk_val(DISPLAY_MODE, MODE_A);
      chk_bit(FAULT_LAMP, 1'h1);
      RESET_N = 1'h1;
      STARTUP_DONE = 1'h1;
      $display("test reset done");
      foreach (rows[i]) begin
         i_fpm_operator.press(10);
         chk_val(DISPLAY_MODE, rows[i].mode);
         chk_bit(SECOND, rows[i].second);
         if (rows[i].chk1) chk_bit(FIRST, rows[i].first);
         else chk_blink(1'h0);
      end
      $display("test mode cycle done");
      repeat (3) i_fpm_operator.press(10);
      PORT_STATE = 8'ha5;
      SUPPLY_STATE = 2'h1;
      i_fpm_operator.press(40);
      chk_val(FAULT_MASK, 16'h0000);
      chk_val(DISPLAY_MODE, MODE_D);
      i_fpm_operator.press(70);
      chk_val(n_mask, 16'h0001);
      chk_val(FAULT_MASK, 16'h01a5);
      chk_bit(n_chase > 0, 1'h1);
      PORT_STATE = 8'ha4;
      repeat (4) @(negedge CORE_CLK);
      chk_bit(FAULT_LAMP, 1'h1);
      chk_bit(CONTACT, 1'h0);
      PORT_STATE = 8'ha5;
      repeat (4) @(negedge CORE_CLK);
      chk_bit(FAULT_LAMP, 1'h0);
      chk_bit(CONTACT, 1'h1);
      $display("test fault mask done");
      OTHER_FAULT = 1'h1;
      repeat (4) @(negedge CORE_CLK);
      chk_bit(FAULT_LAMP, 1'h1);
      chk_bit(CONTACT, 1'h0);
      {OTHER_FAULT, STARTUP_ERROR} = 2'h1;
      repeat (4) @(negedge CORE_CLK);
      chk_bit(FAULT_LAMP, 1'h1);
      chk_bit(CONTACT, 1'h0);
      {STARTUP_ERROR, FIRMWARE_ERROR} = 2'h1;
      chk_blink(1'h1);
      chk_bit(CONTACT, 1'h0);
      STARTUP_DONE = 1'h0;
      chk_blink(1'h1);
      {STARTUP_DONE, FIRMWARE_ERROR} = 2'h2;
      repeat (4) @(negedge CORE_CLK);
      chk_bit(FAULT_LAMP, 1'h0);
      chk_bit(CONTACT, 1'h1);
      $display("test fault sources done");
      for (int i = 0; i < 64; i++) begin
         {RING_STATUS, LINK_STATUS} = 6'(i);
         repeat (7) @(negedge CORE_CLK);
      end
      chk_val(DISPLAY_MODE, MODE_A);
      $display("test idle return done");
      RESTORE_BTN_ENA = 1'h0;
      i_fpm_operator.press(140);
      chk_val(n_restore, 16'h0000);
      RESTORE_BTN_ENA = 1'h1;
      i_fpm_operator.press(100);
      chk_val(n_restore, 16'h0000);
      n_chase = 0;
      i_fpm_operator.press(140);
      chk_val(n_restore, 16'h0001);
      chk_val(n_chase, 16'h001e);
      chk_val(FAULT_MASK, 16'h0000);
      STARTUP_DONE = 1'h0;
      RESTORE_BTN_ENA = 1'h0;
      i_fpm_operator.press(140);
      chk_val(n_restore, 16'h0002);
      i_fpm_operator.press(10);
      i_fpm_operator.press(140);
      chk_val(n_restore, 16'h0002);
      chk_val(DISPLAY_MODE, MODE_B);
      $display("test factory restore done");
      RESET_N = 1'h0;
      @(negedge CORE_CLK);
      chk_val(DISPLAY_MODE, MODE_A);
      chk_bit(FIRST, 1'h0);
      RESET_N = 1'h1;
      repeat (2) @(negedge CORE_CLK);
      chk_bit(FAULT_LAMP, 1'h1);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule

// file: src/fpm_front_panel.sv
`timescale 1ns/1ps
// Operation
// - brief press advances the display mode
// - modes step A, B, C, D, E, wrap
// - one idle minute returns display to A
// - five modes, A after reset
// - mode lamps encode mode, E flashes first
// - restore hold only in mode A
// - twelve second hold triggers factory restore
// - flash and port chase from nine seconds
// - early release abandons the restore
// - restore returns all settings to defaults
// - configuration bit disables restore in operation
// - restore disable ignored until startup completes
// - mask hold only in mode D
// - five second hold stores good status
// - flash and port chase from two seconds
// - early release keeps previous fault mask
// - deviation from good status is fault
// - ring manager lamp off, steady, flashing
// - standby lamp shows standby function state
// - interconnection lamp shows redundancy availability
// - startup fault lamp steady, flashing, off
// - operation fault lamp and signalling contact
module fpm_front_panel
   import fpm_pkg::*;
#(
   parameter int unsigned NUM_PORTS         = NUM_PORTS_DEF,
   parameter int unsigned IDLE_CYCLES       = IDLE_CYC,
   parameter int unsigned RESTORE_HOLD_CYCLES  = RESTORE_HOLD_CYC,
   parameter int unsigned RESTORE_FLASH_CYCLES = RESTORE_FLASH_CYC,
   parameter int unsigned MASK_HOLD_CYCLES  = MASK_HOLD_CYC,
   parameter int unsigned MASK_FLASH_CYCLES = MASK_FLASH_CYC,
   parameter int unsigned FLASH_LEN_CYCLES  = FLASH_LEN_CYC,
   parameter int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_CYC,
   parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
   input  wire logic                             CORE_CLK,
   input  wire logic                             RESET_N,
   input  wire logic                             BUTTON_N,
   input  wire logic                             RESTORE_BTN_ENA,
   input  wire logic                             STARTUP_DONE,
   input  wire logic                             STARTUP_ERROR,
   input  wire logic                             FIRMWARE_ERROR,
   input  wire logic                             OTHER_FAULT,
   input  wire logic [NUM_PORTS-1:0]             PORT_STATE,
   input  wire logic [NUM_SUPPLY-1:0]            SUPPLY_STATE,
   input  wire fpm_ring_t                        RING_STATUS,
   input  wire fpm_link_t                        LINK_STATUS,
   output logic                                  MODE_INDICATOR_FIRST,
   output logic                                  MODE_INDICATOR_SECOND,
   output logic [2:0]                            DISPLAY_MODE,
   output logic [NUM_PORTS-1:0]                  PORT_CHASE,
   output logic                                  PORT_CHASE_ACTIVE,
   output logic                                  RING_MANAGER_LAMP,
   output logic                                  REDUNDANT_LINK_LAMP,
   output logic                                  FAULT_LAMP,
   output logic                                  SIGNAL_CONTACT_CLOSED,
   output logic                                  FACTORY_RESTORE,
   output logic                                  MASK_STORED,
   output logic [NUM_PORTS+NUM_SUPPLY-1:0]       FAULT_MASK
);

   localparam int unsigned WATCH_W = NUM_PORTS + NUM_SUPPLY;
   localparam int unsigned IDX_W   = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
   localparam int unsigned STEP_CYC = (FLASH_LEN_CYCLES / NUM_PORTS > 0) ? FLASH_LEN_CYCLES / NUM_PORTS : 1;
   localparam logic [WATCH_W-1:0] MASK_RESET = '0;

   // ****************************************
   // parameter checks
   // ****************************************
   if (NUM_PORTS < 1 || NUM_PORTS > 64)
      $error("fpm_front_panel: NUM_PORTS out of range");
   if (MASK_FLASH_CYCLES == 0 || MASK_FLASH_CYCLES >= MASK_HOLD_CYCLES)
      $error("fpm_front_panel: mask flash start must precede mask hold");
   if (RESTORE_FLASH_CYCLES >= RESTORE_HOLD_CYCLES || MASK_FLASH_CYCLES > RESTORE_FLASH_CYCLES)
      $error("fpm_front_panel: restore timing inconsistent");
   if (DEBOUNCE_CYCLES == 0 || BLINK_HALF_CYCLES == 0 || IDLE_CYCLES == 0)
      $error("fpm_front_panel: zero count not supported");

   // ****************************************
   // button synchroniser and debouncer
   // ****************************************
   logic        sync1_ff;
   logic        sync2_ff;
   logic        btn_db_ff;
   logic [31:0] db_cnt_ff;
   wire         raw_pressed  = ~sync2_ff;
   wire         db_differs   = raw_pressed != btn_db_ff;
   wire         db_settled   = db_differs && (db_cnt_ff >= DEBOUNCE_CYCLES - 1);
   wire  [31:0] nxt_db_cnt   = db_differs ? db_cnt_ff + CNT_ONE : CNT_ZERO;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync1_ff  <= 1'b1;
         sync2_ff  <= 1'b1;
         btn_db_ff <= 1'b0;
         db_cnt_ff <= CNT_ZERO;
      end else begin
         sync1_ff  <= BUTTON_N;
         sync2_ff  <= sync1_ff;
         btn_db_ff <= db_settled ? raw_pressed : btn_db_ff;
         db_cnt_ff <= db_settled ? CNT_ZERO : nxt_db_cnt;
      end
   end

   // ****************************************
   // press timing and hold state
   // ****************************************
   fpm_hold_t   hold_ff;
   fpm_hold_t   nxt_hold;
   fpm_mode_t   mode_ff;
   fpm_mode_t   next_mode;
   logic [31:0] hold_cnt_ff;
   logic [31:0] idle_cnt_ff;

   wire restore_allow  = RESTORE_BTN_ENA || !STARTUP_DONE;
   wire restore_elig   = mode_ff == MODE_A && restore_allow;
   wire mask_elig      = mode_ff == MODE_D;
   wire in_hold        = hold_ff == ST_HOLD && btn_db_ff;
   wire restore_fire   = in_hold && restore_elig && hold_cnt_ff >= RESTORE_HOLD_CYCLES - 1;
   wire mask_fire      = in_hold && mask_elig && hold_cnt_ff >= MASK_HOLD_CYCLES - 1;
   wire brief_press    = hold_ff == ST_HOLD && !btn_db_ff && hold_cnt_ff < MASK_FLASH_CYCLES;
   wire restore_window = in_hold && restore_elig && hold_cnt_ff >= RESTORE_FLASH_CYCLES;
   wire mask_window    = in_hold && mask_elig && hold_cnt_ff >= MASK_FLASH_CYCLES;
   wire flash_window   = restore_window || mask_window;
   wire idle_expired   = idle_cnt_ff >= IDLE_CYCLES - 1;

   always_comb begin
      nxt_hold = hold_ff;
      unique case (hold_ff)
         ST_IDLE: if (btn_db_ff) nxt_hold = ST_HOLD;
         ST_HOLD: begin
            if (!btn_db_ff)
               nxt_hold = ST_IDLE;
            else if (restore_fire || mask_fire)
               nxt_hold = ST_DONE;
         end
         ST_DONE: if (!btn_db_ff) nxt_hold = ST_IDLE;
         default: nxt_hold = ST_IDLE;
      endcase
   end

   always_comb begin
      unique case (mode_ff)
         MODE_A:  next_mode = MODE_B;
         MODE_B:  next_mode = MODE_C;
         MODE_C:  next_mode = MODE_D;
         MODE_D:  next_mode = MODE_E;
         MODE_E:  next_mode = MODE_A;
         default: next_mode = MODE_A;
      endcase
   end

   wire fpm_mode_t nxt_mode =
      restore_fire ? MODE_A :
      brief_press  ? next_mode :
      idle_expired ? MODE_A :
      mode_ff;
   wire [31:0] nxt_hold_cnt = (hold_ff == ST_IDLE) ? CNT_ZERO : hold_cnt_ff + CNT_ONE;
   wire [31:0] nxt_idle_cnt = (btn_db_ff || hold_ff != ST_IDLE || idle_expired) ? CNT_ZERO
                                                                                : idle_cnt_ff + CNT_ONE;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hold_ff     <= ST_IDLE;
         mode_ff     <= MODE_A;
         hold_cnt_ff <= CNT_ZERO;
         idle_cnt_ff <= CNT_ZERO;
      end else begin
         hold_ff     <= nxt_hold;
         mode_ff     <= nxt_mode;
         hold_cnt_ff <= nxt_hold_cnt;
         idle_cnt_ff <= nxt_idle_cnt;
      end
   end

   // ****************************************
   // blink divider and port chase
   // ****************************************
   logic             blink_ff;
   logic [31:0]      blink_cnt_ff;
   logic [31:0]      step_cnt_ff;
   logic [IDX_W-1:0] chase_idx_ff;

   wire             blink_wrap = blink_cnt_ff >= BLINK_HALF_CYCLES - 1;
   wire             step_wrap  = step_cnt_ff >= STEP_CYC - 1;
   wire             idx_last   = chase_idx_ff == IDX_W'(NUM_PORTS - 1);
   wire [IDX_W-1:0] nxt_idx    = !flash_window ? '0 :
                                 !step_wrap    ? chase_idx_ff :
                                 idx_last      ? '0 : chase_idx_ff + IDX_W'(1);
   wire [31:0]      nxt_step   = (!flash_window || step_wrap) ? CNT_ZERO : step_cnt_ff + CNT_ONE;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         blink_ff     <= 1'b0;
         blink_cnt_ff <= CNT_ZERO;
         step_cnt_ff  <= CNT_ZERO;
         chase_idx_ff <= '0;
      end else begin
         blink_ff     <= blink_wrap ? ~blink_ff : blink_ff;
         blink_cnt_ff <= blink_wrap ? CNT_ZERO : blink_cnt_ff + CNT_ONE;
         step_cnt_ff  <= nxt_step;
         chase_idx_ff <= nxt_idx;
      end
   end

   // ****************************************
   // fault mask
   // ****************************************
   logic [WATCH_W-1:0] mask_ff;
   wire  [WATCH_W-1:0] watch_now = {SUPPLY_STATE, PORT_STATE};
   wire  [WATCH_W-1:0] nxt_mask  = restore_fire ? MASK_RESET :
                                   mask_fire    ? watch_now :
                                   mask_ff;
   wire                deviation = watch_now != mask_ff;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N)
         mask_ff <= MASK_RESET;
      else
         mask_ff <= nxt_mask;
   end

   // ****************************************
   // lamp decoding
   // ****************************************
   wire mode_first  = (mode_ff == MODE_B) || (mode_ff == MODE_D) || (mode_ff == MODE_E && blink_ff);
   wire mode_second = (mode_ff == MODE_C) || (mode_ff == MODE_D);
   wire nxt_first   = flash_window ? blink_ff : mode_first;
   wire nxt_second  = flash_window ? blink_ff : mode_second;

   wire nxt_ring    = RING_STATUS.is_manager && (!RING_STATUS.ring_break || blink_ff);
   wire link_flash  = LINK_STATUS.use_interconnect ? !LINK_STATUS.redundancy_ok
                                                   : LINK_STATUS.standby_active;
   wire nxt_link    = LINK_STATUS.func_enabled && (!link_flash || blink_ff);

   wire op_fault    = deviation || OTHER_FAULT;
   wire nxt_fault   = !STARTUP_DONE ? (FIRMWARE_ERROR ? blink_ff : 1'b1) :
                      FIRMWARE_ERROR ? blink_ff :
                      STARTUP_ERROR || op_fault;
   wire nxt_contact = STARTUP_DONE && !FIRMWARE_ERROR && !STARTUP_ERROR && !op_fault;

   wire [NUM_PORTS-1:0] nxt_chase = flash_window ? (NUM_PORTS'(1) << chase_idx_ff) : '0;

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         MODE_INDICATOR_FIRST  <= 1'b0;
         MODE_INDICATOR_SECOND <= 1'b0;
         DISPLAY_MODE          <= 3'h0;
         PORT_CHASE            <= '0;
         PORT_CHASE_ACTIVE     <= 1'b0;
         RING_MANAGER_LAMP     <= 1'b0;
         REDUNDANT_LINK_LAMP   <= 1'b0;
         FAULT_LAMP            <= 1'b1;
         SIGNAL_CONTACT_CLOSED <= 1'b0;
         FACTORY_RESTORE       <= 1'b0;
         MASK_STORED           <= 1'b0;
         FAULT_MASK            <= MASK_RESET;
      end else begin
         MODE_INDICATOR_FIRST  <= nxt_first;
         MODE_INDICATOR_SECOND <= nxt_second;
         DISPLAY_MODE          <= nxt_mode;
         PORT_CHASE            <= nxt_chase;
         PORT_CHASE_ACTIVE     <= flash_window;
         RING_MANAGER_LAMP     <= nxt_ring;
         REDUNDANT_LINK_LAMP   <= nxt_link;
         FAULT_LAMP            <= nxt_fault;
         SIGNAL_CONTACT_CLOSED <= nxt_contact;
         FACTORY_RESTORE       <= restore_fire;
         MASK_STORED           <= mask_fire;
         FAULT_MASK            <= nxt_mask;
      end
   end

endmodule

// file: src/fpm_pkg.sv
package fpm_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned IDLE_S          = 60;
   localparam int unsigned RESTORE_HOLD_S  = 12;
   localparam int unsigned RESTORE_FLASH_S = 9;
   localparam int unsigned MASK_HOLD_S     = 5;
   localparam int unsigned MASK_FLASH_S    = 2;
   localparam int unsigned FLASH_LEN_S     = 3;
   localparam int unsigned DEBOUNCE_MS     = 10;
   localparam int unsigned BLINK_HALF_MS   = 250;

   localparam int unsigned IDLE_CYC          = IDLE_S * CLK_HZ;
   localparam int unsigned RESTORE_HOLD_CYC  = RESTORE_HOLD_S * CLK_HZ;
   localparam int unsigned RESTORE_FLASH_CYC = RESTORE_FLASH_S * CLK_HZ;
   localparam int unsigned MASK_HOLD_CYC     = MASK_HOLD_S * CLK_HZ;
   localparam int unsigned MASK_FLASH_CYC    = MASK_FLASH_S * CLK_HZ;
   localparam int unsigned FLASH_LEN_CYC     = FLASH_LEN_S * CLK_HZ;
   localparam int unsigned DEBOUNCE_CYC      = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int unsigned BLINK_HALF_CYC    = BLINK_HALF_MS * (CLK_HZ / 1000);

   // ****************************************
   // sizes and reset values
   // ****************************************
   localparam int unsigned NUM_PORTS_DEF = 8;
   localparam int unsigned NUM_SUPPLY    = 2;
   localparam logic [31:0] CNT_ZERO      = 32'h0000_0000;
   localparam logic [31:0] CNT_ONE       = 32'h0000_0001;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      MODE_A = 3'h0,
      MODE_B = 3'h1,
      MODE_C = 3'h3,
      MODE_D = 3'h2,
      MODE_E = 3'h6
   } fpm_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_HOLD = 2'h1,
      ST_DONE = 2'h3
   } fpm_hold_t;

   typedef struct packed {
      logic is_manager;
      logic ring_break;
   } fpm_ring_t;

   typedef struct packed {
      logic use_interconnect;
      logic func_enabled;
      logic standby_active;
      logic redundancy_ok;
   } fpm_link_t;

endpackage
